// file: logic/eeprom_map.vh
// Constants of the two-wire serial memory slave: address layout and field positions.
// Included by the slave and the bench; definitions only.
`ifndef EEPROM_MAP_VH
`define EEPROM_MAP_VH
// Array size and address width.
`define MEM_DEPTH 512
`define MEM_AW 9
// Device-type field; the value is arbitrary.
`define DEV_TYPE 4'h5
// Slave address byte field positions.
`define SA_TYPE_HI 7
`define SA_TYPE_LO 4
`define SA_SEL_HI 3
`define SA_SEL_LO 2
`define SA_PAGE_BIT 1
`define SA_DIR_BIT 0
// Reset value and byte bit count.
`define ADDR_RST 9'h000
`define BYTE_BITS 4'h8
`endif

// file: logic/eeprom_store.v
// Byte-wide storage array of the serial memory slave, one read and one write port.
// Assumes a single clock; read data appears one cycle after the address.
`timescale 1ns/1ps
`default_nettype none
module eeprom_store #(
    parameter DEPTH = 512,
    parameter AW = 9
) (
    // Clock.
    input wire sys_clk,
    // Write port.
    input wire wr_en,
    input wire [AW-1:0] wr_addr,
    input wire [7:0] wr_data,
    // Read port.
    input wire [AW-1:0] rd_addr,
    output reg [7:0] rd_data
);
    reg [7:0] mem [0:DEPTH-1];

    // Synchronous write and registered read.
    always @(posedge sys_clk) begin
        if (wr_en) begin
            mem[wr_addr] <= wr_data;
        end
        rd_data <= mem[rd_addr];
    end
endmodule // eeprom_store
`default_nettype wire

// file: logic/eeprom_slave.v
// Two-wire serial memory slave of 512 bytes: reads of all forms plus simple byte writes.
// Assumes scl and sda_i come from pins, asynchronous to sys_clk, and are oversampled.
//
// Contract
// RQ1 - A read opens with a start and the slave address whose direction bit is one.
// RQ2 - The master ends a read by stop in the ninth cycle or by leaving SDA high there.
// RQ3 - The address counter holds the last accessed location plus one after reads and writes.
// RQ4 - On a read address match the device acknowledges and shifts out the byte at the counter.
// RQ5 - The master ends any read with no acknowledge followed by a stop.
// RQ6 - A random read is prefaced by a dummy write carrying only the word address.
// RQ7 - After the word address acknowledge the master repeats start with a read address.
// RQ8 - After the repeated start the device sends the byte at the loaded word address.
// RQ9 - Each master acknowledge asks for one more byte, until one is withheld.
// RQ10 - During reads the counter advances over all its bits after each byte.
// RQ11 - Past the top location the counter wraps to zero and streaming continues.
// RQ12 - A sequential read may start as a current-address or a random read.
// RQ13 - The slave address is type field, two select bits, ninth address bit, direction bit.
// RQ14 - Start is SDA falling with SCL high, stop is SDA rising with SCL high; nothing before start.
// RQ15 - After eight bits the device releases SDA; without acknowledge it waits for stop.
// RQ16 - SDA is changed only while SCL is low and is only ever pulled low.
// RQ17 - A stop abandons the transfer and returns to idle, keeping the address counter.
`timescale 1ns/1ps
`include "eeprom_map.vh"
`default_nettype none
module eeprom_slave #(
    parameter DEPTH = `MEM_DEPTH,
    parameter AW = `MEM_AW
) (
    // Clock and reset.
    input wire sys_clk,
    input wire resetn,
    // Two-wire bus pins.
    input wire scl,
    input wire sda_i,
    output wire sda_o,
    output wire sda_oe,
    // Select straps.
    input wire select_pin_low,
    input wire select_pin_high
);
    // One-hot states.
    localparam [6:0] ST_IDLE = 7'h01;
    localparam [6:0] ST_SADDR = 7'h02;
    localparam [6:0] ST_SACK = 7'h04;
    localparam [6:0] ST_WADDR = 7'h08;
    localparam [6:0] ST_WDATA = 7'h10;
    localparam [6:0] ST_TX = 7'h20;
    localparam [6:0] ST_MACK = 7'h40;

    reg [2:0] scl_s, sda_s;
    reg [1:0] sel_lo_s;
    reg [1:0] sel_hi_s;
    reg [6:0] state_q;
    reg [3:0] bit_q;
    reg [7:0] shift_q;
    reg [AW-1:0] addr_q;
    reg [AW-1:0] waddr_q;
    reg rd_q;
    reg sda_low_q;
    reg wr_en_q;
    reg [7:0] wr_data_q;
    wire [7:0] mem_q;

    // Pins pass three flops; only the second and third stages are read.
    // The select straps are pins too, so they get a two-flop guard, read at the second stage.
    always @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            scl_s <= 3'h7;
            sda_s <= 3'h7;
            sel_lo_s <= 2'h0;
            sel_hi_s <= 2'h0;
        end else begin
            scl_s <= {scl_s[1:0], scl};
            sda_s <= {sda_s[1:0], sda_i};
            sel_lo_s <= {sel_lo_s[0], select_pin_low};
            sel_hi_s <= {sel_hi_s[0], select_pin_high};
        end
    end

    wire scl_h = scl_s[1];
    wire scl_rise = scl_s[1] & ~scl_s[2];
    wire scl_fall = ~scl_s[1] & scl_s[2];
    wire start_ev = scl_h & scl_s[2] & ~sda_s[1] & sda_s[2]; // RQ14
    wire stop_ev = scl_h & scl_s[2] & sda_s[1] & ~sda_s[2]; // RQ14
    wire [7:0] rx_byte = {shift_q[6:0], sda_s[1]};

    // Address byte match on type field and select straps.
    function addr_match;
        input [7:0] b;
        input s_hi;
        input s_lo;
        begin
            addr_match = (b[`SA_TYPE_HI:`SA_TYPE_LO] == `DEV_TYPE) &&
                         (b[`SA_SEL_HI] == s_hi) && (b[`SA_SEL_LO] == s_lo); // RQ13
        end
    endfunction

    eeprom_store #(.DEPTH(DEPTH), .AW(AW)) u_store (
        .sys_clk(sys_clk),
        .wr_en(wr_en_q),
        .wr_addr(waddr_q),
        .wr_data(wr_data_q),
        .rd_addr(addr_q),
        .rd_data(mem_q)
    );

    // Open-drain drive: only ever low, enable high while pulling.
    assign sda_o = 1'b0; // RQ16
    assign sda_oe = sda_low_q; // RQ16

    // Protocol engine; all SDA changes are made on the SCL falling edge.
    always @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            state_q <= ST_IDLE;
            bit_q <= 4'h0;
            shift_q <= 8'h00;
            addr_q <= `ADDR_RST;
            waddr_q <= `ADDR_RST;
            rd_q <= 1'b0;
            sda_low_q <= 1'b0;
            wr_en_q <= 1'b0;
            wr_data_q <= 8'h00;
        end else begin
            wr_en_q <= 1'b0;
            if (stop_ev) begin
                state_q <= ST_IDLE; // RQ17
                sda_low_q <= 1'b0;
            end else if (start_ev) begin
                state_q <= ST_SADDR; // RQ14 RQ7
                bit_q <= 4'h0;
                sda_low_q <= 1'b0;
            end else begin
                case (state_q)
                    ST_IDLE: begin
                        sda_low_q <= 1'b0; // RQ14
                    end
                    ST_SADDR: begin
                        if (scl_rise) begin
                            shift_q <= rx_byte;
                            bit_q <= bit_q + 4'h1;
                        end else if (scl_fall && bit_q == `BYTE_BITS) begin
                            if (addr_match(shift_q, sel_hi_s[1], sel_lo_s[1])) begin
                                sda_low_q <= 1'b1;
                                rd_q <= shift_q[`SA_DIR_BIT]; // RQ1
                                addr_q[AW-1] <= shift_q[`SA_PAGE_BIT]; // RQ13
                                state_q <= ST_SACK;
                            end else begin
                                state_q <= ST_IDLE;
                            end
                        end
                    end
                    ST_SACK: begin
                        // Acknowledge stands for the ninth clock, then the next phase begins.
                        if (scl_fall) begin
                            bit_q <= 4'h0;
                            if (rd_q) begin
                                state_q <= ST_TX; // RQ4 RQ8 RQ12
                                shift_q <= mem_q;
                                sda_low_q <= ~mem_q[7];
                                addr_q <= addr_q + 1'b1; // RQ3 RQ10 RQ11
                            end else begin
                                sda_low_q <= 1'b0;
                                state_q <= (bit_q == `BYTE_BITS) ? ST_WADDR : ST_WDATA;
                            end
                        end
                    end
                    ST_WADDR: begin
                        if (scl_rise) begin
                            shift_q <= rx_byte;
                            bit_q <= bit_q + 4'h1;
                        end else if (scl_fall && bit_q == `BYTE_BITS) begin
                            addr_q[7:0] <= shift_q; // RQ6
                            sda_low_q <= 1'b1;
                            bit_q <= 4'h9;
                            state_q <= ST_SACK;
                        end
                    end
                    ST_WDATA: begin
                        if (scl_rise) begin
                            shift_q <= rx_byte;
                            bit_q <= bit_q + 4'h1;
                        end else if (scl_fall && bit_q == `BYTE_BITS) begin
                            wr_en_q <= 1'b1;
                            waddr_q <= addr_q;
                            wr_data_q <= shift_q;
                            addr_q <= addr_q + 1'b1; // RQ3
                            sda_low_q <= 1'b1;
                            bit_q <= 4'h9;
                            state_q <= ST_SACK;
                        end
                    end
                    ST_TX: begin
                        if (scl_fall) begin
                            if (bit_q == 4'h7) begin
                                sda_low_q <= 1'b0; // RQ15
                                state_q <= ST_MACK;
                            end else begin
                                sda_low_q <= ~shift_q[6];
                                shift_q <= {shift_q[6:0], 1'b0};
                            end
                            bit_q <= bit_q + 4'h1;
                        end
                    end
                    ST_MACK: begin
                        if (scl_rise) begin
                            rd_q <= ~sda_s[1]; // RQ2 RQ5
                        end else if (scl_fall) begin
                            if (rd_q) begin
                                state_q <= ST_TX; // RQ9
                                bit_q <= 4'h0;
                                shift_q <= mem_q;
                                sda_low_q <= ~mem_q[7];
                                addr_q <= addr_q + 1'b1; // RQ10 RQ11
                            end else begin
                                state_q <= ST_IDLE; // RQ15
                            end
                        end
                    end
                    default: begin
                        state_q <= ST_IDLE;
                        sda_low_q <= 1'b0;
                    end
                endcase
            end
        end
    end
endmodule // eeprom_slave
`default_nettype wire

// file: tb/eeprom_slave_properties.sv
// Pin checker of the serial memory slave.
// Assumes bus clock phases last several system clocks.
`timescale 1ns/1ps
`default_nettype none
module eeprom_slave_properties (
    // Clock and reset.
    input wire logic sys_clk,
    input wire logic resetn,
    // Bus pins and straps.
    input wire logic scl,
    input wire logic sda_i,
    input wire logic sda_o,
    input wire logic sda_oe,
    input wire logic select_pin_low,
    input wire logic select_pin_high
);
    // Checks run on the system clock; all but a_reset_quiet rest during reset.
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!resetn);
    a_drive_low_only: assert property (sda_oe |-> !sda_o) else $error("sda driven high");
    a_oe_rise_low: assert property ($rose(sda_oe) |-> !scl) else $error("drive at scl high");
    a_oe_fall_low: assert property ($fell(sda_oe) |-> !scl) else $error("release at scl high");
    a_steady_scl_high: assert property (scl && $past(scl) |-> $stable(sda_oe))
        else $error("sda moved while scl high");
    a_low_bit_held: assert property ($rose(sda_oe) |-> sda_oe [*8]) else $error("low too short");
    a_release_held: assert property ($fell(sda_oe) |-> !sda_oe [*8]) else $error("gap too short");
    a_stop_quiet: assert property (scl && $rose(sda_i) |-> !sda_oe [*8])
        else $error("drive after stop");
    a_reset_quiet: assert property (disable iff (1'b0) !resetn |-> !sda_oe)
        else $error("drive in reset");
    // Main scenarios: a pulled bit, a stop, a low level during a high clock.
    c_pull: cover property ($rose(sda_oe));
    c_stop: cover property (scl && $rose(sda_i));
    c_low_high: cover property (sda_oe && scl);
endmodule // eeprom_slave_properties
bind eeprom_slave eeprom_slave_properties u_eeprom_slave_properties (.sys_clk(sys_clk),
    .resetn(resetn), .scl(scl), .sda_i(sda_i), .sda_o(sda_o), .sda_oe(sda_oe),
    .select_pin_low(select_pin_low), .select_pin_high(select_pin_high));
`default_nettype wire

// file: tb/bus_master.sv
// Two-wire bus master model: drives the bus clock and pulls the data line low.
// Assumes the bench resolves the data line with a pull-up.
`timescale 1ns/1ps
`default_nettype none
module bus_master (
    // System clock and resolved data line.
    input wire logic sys_clk,
    input wire logic sda_line,
    // Bus clock and data pull-down.
    output var logic scl,
    output var logic pull
);
    // Idle bus: clock high, data released.
    initial begin
        scl = 1'b1;
        pull = 1'b0;
    end
    // Sets both lines at this edge, then waits n edges.
    task automatic step(input logic c, input logic p, input int n);
        scl <= c;
        pull <= p;
        repeat (n) @(posedge sys_clk);
    endtask
    // Start lowers the clock first so a held low data line makes no stop.
    task automatic start();
        step(1'b0, pull, 3);
        step(1'b0, 1'b0, 3);
        step(1'b1, 1'b0, 4);
        step(1'b1, 1'b1, 4);
    endtask
    // Stop, then a quiet gap before any further start.
    task automatic stop();
        step(1'b0, pull, 3);
        step(1'b0, 1'b1, 3);
        step(1'b1, 1'b1, 4);
        step(1'b1, 1'b0, 10);
    endtask
    // One bit of ten system clocks: data set mid low phase, sampled late in the high phase.
    task automatic bit_io(input logic b, output logic r);
        step(1'b0, pull, 2);
        step(1'b0, !b, 3);
        step(1'b1, !b, 4);
        r = sda_line;
        repeat (1) @(posedge sys_clk);
    endtask
    // Eight bits MSB first, then the ninth bit; a one there withholds acknowledge.
    task automatic byte_io(input logic [7:0] d, input logic a, output logic [7:0] r,
        output logic k);
        for (int i = 7; i >= 0; i--) bit_io(d[i], r[i]);
        bit_io(a, k);
    endtask
endmodule // bus_master
`default_nettype wire

// file: tb/tb.sv
// Self-checking bench of the serial memory slave and a bus master model.
// Assumes the map header is on the include path.
`timescale 1ns/1ps
`include "eeprom_map.vh"
`default_nettype none
`define CHECK(nm, e, g) begin tests_run++; if ((g) !== (e)) begin n_fail++; \
    $display("Error %s expected %h seen %h", nm, e, g); end end
module tb;
    logic sys_clk = 1'b0;
    logic resetn = 1'b1;
    logic sel_lo = 1'b1;
    logic sel_hi = 1'b0;
    logic [7:0] rd;
    logic ak;
    int n_fail = 0;
    int tests_run = 0;
    wire scl;
    wire pull;
    wire sda_o;
    wire sda_oe;
    // Open-drain data line with a pull-up.
    wire sda_line = !pull && !(sda_oe && !sda_o);
    // Bytes stored around the top of the array and past its wrap.
    logic [8:0] exp_addr [5] = '{9'h1FE, 9'h1FF, 9'h000, 9'h001, 9'h002};
    logic [7:0] exp_data [5] = '{8'hA1, 8'hB2, 8'hC3, 8'hD4, 8'h5E};
    eeprom_slave u_eeprom_slave (.sys_clk(sys_clk), .resetn(resetn), .scl(scl),
        .sda_i(sda_line), .sda_o(sda_o), .sda_oe(sda_oe), .select_pin_low(sel_lo),
        .select_pin_high(sel_hi));
    bus_master u_bus_master (.sys_clk(sys_clk), .sda_line(sda_line), .scl(scl), .pull(pull));
    // System clock of 5 ns.
    always #2.5 sys_clk = ~sys_clk;
    function automatic logic [7:0] sa(input logic a8, input logic rw);
        return {`DEV_TYPE, sel_hi, sel_lo, a8, rw};
    endfunction
    task automatic xfer(input logic [7:0] d, input logic a);
        u_bus_master.byte_io(d, a, rd, ak);
    endtask
    task automatic wr(input logic [8:0] a, input logic [7:0] d);
        u_bus_master.start();
        xfer(sa(a[8], 1'b0), 1'b1);
        `CHECK("write ack", 1'b0, ak)
        xfer(a[7:0], 1'b1);
        xfer(d, 1'b1);
        u_bus_master.stop();
    endtask
    // Random read near the top, streaming across the wrap to zero.
    task automatic s_random();
        u_bus_master.start();
        xfer(sa(1'b1, 1'b0), 1'b1);
        xfer(8'hFE, 1'b1);
        u_bus_master.start();
        xfer(sa(1'b1, 1'b1), 1'b1);
        `CHECK("read ack", 1'b0, ak)
        for (int i = 0; i < 3; i++) begin
            xfer(8'hFF, i == 2);
            `CHECK("stream", exp_data[i], rd)
        end
        u_bus_master.stop();
    endtask
    // Current reads in two transfers: the counter survives the stop.
    task automatic s_current();
        for (int i = 3; i < 5; i++) begin
            u_bus_master.start();
            xfer(sa(1'b0, 1'b1), 1'b1);
            `CHECK("current ack", 1'b0, ak)
            xfer(8'hFF, 1'b1);
            `CHECK("current byte", exp_data[i], rd)
        end
        u_bus_master.bit_io(1'b1, ak);
        `CHECK("released", 1'b1, ak)
        u_bus_master.stop();
    endtask
    // A foreign type field and each foreign select bit get no acknowledge.
    task automatic s_mismatch();
        logic [7:0] fa [3];
        fa[0] = {`DEV_TYPE ^ 4'h3, sel_hi, sel_lo, 2'b01};
        fa[1] = {`DEV_TYPE, !sel_hi, sel_lo, 2'b01};
        fa[2] = {`DEV_TYPE, sel_hi, !sel_lo, 2'b01};
        for (int k = 0; k < 3; k++) begin
            u_bus_master.start();
            xfer(fa[k], 1'b1);
            `CHECK("foreign ack", 1'b1, ak)
            u_bus_master.stop();
        end
    endtask
    task automatic summarize();
        $display("tests_run=%0d n_fail=%0d", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    // Main sequence; reset falls at time zero so the asynchronous branch acts at once.
    initial begin
        resetn <= 1'b0;
        repeat (12) @(posedge sys_clk);
        resetn <= 1'b1;
        repeat (4) @(posedge sys_clk);
        for (int i = 0; i < 5; i++) wr(exp_addr[i], exp_data[i]);
        s_random();
        s_current();
        s_mismatch();
        summarize();
    end
    // Watchdog well beyond the expected run of about 2900 cycles.
    initial begin
        repeat (20000) @(posedge sys_clk);
        n_fail++;
        summarize();
    end
endmodule // tb
`default_nettype wire
